// File: scs_current_scaler.sv
`timescale 1ns/10ps
module scs_current_scaler (
  input  wire logic               clk_sys_in,
  input  wire logic               sys_rst_in,
  input  wire logic               meas_valid_in,
  input  wire scs_pkg::scs_meas_t meas_in,
  input  wire scs_pkg::scs_req_t  req_in,
  output scs_pkg::scs_rsp_t       rsp_out,
  output logic                    sweep_done_out
);
  import scs_pkg::*;

  typedef enum logic [1:0] {
    SQ_LAUNCH = 2'b01,
    SQ_WAIT   = 2'b10
  } scs_seq_state_t;

  // fifteen entries: three views of five channels each
  localparam int NUM_ENT = NUM_CH * NUM_BLK;

  // held state
  scs_meas_t      meas_r;
  scs_meas_t      snap_r;
  scs_seq_state_t seq_r;
  logic [1:0]     blk_r;
  logic [2:0]     ch_r;
  logic [15:0]    mult_r [NUM_ENT];
  logic [15:0]    div_r  [NUM_ENT];
  logic [31:0]    res_r  [NUM_ENT];
  logic [31:0]    shadow_r [NUM_CH];
  logic [4:0]     shadow_ovf_r;
  logic [4:0]     ovf16_r;
  logic [4:0]     ovf32_r;
  scs_rsp_t       rsp_r;
  logic           sweep_done_r;

  // combinational helpers
  logic [33:0]    total;
  logic [33:0]    avg;
  logic [33:0]    sel_meas;
  logic [3:0]     ent;
  logic           start;
  logic           sc_done;
  logic [31:0]    sc_result;
  logic           sc_ovf;
  scs_mode_t      sc_mode;
  scs_rsp_t       rsp_nxt;
  logic           wr_hit;
  logic           wr_is_div;
  logic [3:0]     wr_ent;

  // ---------------------------------------------------------------------------
  // measurement capture and derived channels
  // ---------------------------------------------------------------------------
  // latest reading is held; a sweep works on a snapshot so all views agree
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      meas_r <= '0;
    end else if (meas_valid_in) begin
      meas_r <= meas_in;
    end
  end

  // total keeps two spare bits so three full-scale inputs cannot wrap; average truncates
  assign total = 34'(snap_r.cur_a) + 34'(snap_r.cur_b) + 34'(snap_r.cur_c);
  assign avg   = total / 34'd3;
  // flat entry index: view times five plus channel, widened before the product so it cannot wrap
  assign ent   = 4'(blk_r) * 4'(NUM_CH) + 4'(ch_r);

  // route the channel and view under computation to the shared scaler
  always_comb begin
    case (ch_r)
      3'h0:    sel_meas = 34'(snap_r.cur_a);
      3'h1:    sel_meas = 34'(snap_r.cur_b);
      3'h2:    sel_meas = 34'(snap_r.cur_c);
      3'h3:    sel_meas = avg;
      default: sel_meas = total;
    endcase
    case (blk_r)
      2'h0:    sc_mode = SCS_MODE_I16;
      2'h1:    sc_mode = SCS_MODE_I32;
      default: sc_mode = SCS_MODE_FLT;
    endcase
  end

  // ---------------------------------------------------------------------------
  // sweep sequencer: every block, every channel, round and round
  // ---------------------------------------------------------------------------
  // the scaler is idle whenever the sequencer sits in launch, so start is never lost
  assign start = seq_r == SQ_LAUNCH;

  // one computation in flight at a time; the scaler's done pulse moves the sweep on
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      seq_r        <= SQ_LAUNCH;
      blk_r        <= 2'h0;
      ch_r         <= 3'h0;
      snap_r       <= '0;
      sweep_done_r <= 1'b0;
    end else begin
      sweep_done_r <= 1'b0;
      case (seq_r)
        SQ_LAUNCH: begin
          // the scaler samples this entry's operand now, so the snapshot must already be in place
          seq_r <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (sc_done) begin
            seq_r <= SQ_LAUNCH;
            if (ch_r == 3'(NUM_CH - 1)) begin
              ch_r <= 3'h0;
              if (blk_r == 2'(NUM_BLK - 1)) begin
                // freeze the reading for the next sweep before its first launch uses it
                blk_r        <= 2'h0;
                snap_r       <= meas_r;
                sweep_done_r <= 1'b1;
              end else begin
                blk_r <= blk_r + 2'h1;
              end
            end else begin
              ch_r <= ch_r + 3'h1;
            end
          end
        end
        default: begin
          seq_r <= SQ_LAUNCH;
        end
      endcase
    end
  end

  // single shared scaler, time-multiplexed over all fifteen entries to save multipliers
  scs_scaler u_scaler (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (start),
    .mode_in    (sc_mode),
    .meas_in    (sel_meas),
    .mult_in    (mult_r[ent]),
    .div_in     (div_r[ent]),
    .done_out   (sc_done),
    .result_out (sc_result),
    .ovf_out    (sc_ovf)
  );

  // ---------------------------------------------------------------------------
  // result banks: a block is staged, then committed at once
  // ---------------------------------------------------------------------------
  // staging keeps a half-updated block from ever being read out
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      shadow_ovf_r <= 5'h00;
    end else if (sc_done) begin
      shadow_ovf_r[ch_r] <= sc_ovf;
    end
  end

  // channel results wait here until the block's last channel is done
  for (genvar g = 0; g < NUM_CH; g++) begin : g_shadow
    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        shadow_r[g] <= 32'h00000000;
      end else if (sc_done && ch_r == 3'(g)) begin
        shadow_r[g] <= sc_result;
      end
    end
  end

  // commit the whole block on its last channel's done pulse
  for (genvar g = 0; g < NUM_ENT; g++) begin : g_bank
    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        res_r[g] <= 32'h00000000;
      end else if (sc_done && ch_r == 3'(NUM_CH - 1) && blk_r == 2'(g / NUM_CH)) begin
        res_r[g] <= (g % NUM_CH == NUM_CH - 1) ? sc_result : shadow_r[g % NUM_CH];
      end
    end
  end

  // whole overflow word replaced per block, so bits rise and fall together
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ovf16_r <= 5'h00;
      ovf32_r <= 5'h00;
    end else if (sc_done && ch_r == 3'(NUM_CH - 1)) begin
      // the last channel's flag is still on the scaler output, the others are staged
      if (blk_r == 2'h0) begin
        ovf16_r <= {sc_ovf, shadow_ovf_r[3:0]};
      end else if (blk_r == 2'h1) begin
        ovf32_r <= {sc_ovf, shadow_ovf_r[3:0]};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // scaling registers, read/write
  // ---------------------------------------------------------------------------
  // a zero divider is refused: it would make that view and channel's result meaningless
  always_comb begin
    wr_hit    = 1'b0;
    wr_is_div = req_in.addr[0];
    wr_ent    = 4'h0;
    // scaling words pair up: even offset multiplier, odd offset divider
    for (int b = 0; b < NUM_BLK; b++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (req_in.addr[15:1] ==
            15'((ADDR_SCALE_BASE + 16'(b) * ADDR_SCALE_STEP + 16'(2 * c)) >> 1)) begin
          wr_hit = 1'b1;
          wr_ent = 4'(b * NUM_CH + c);
        end
      end
    end
  end

  // one multiplier and one divider per view and channel
  for (genvar g = 0; g < NUM_ENT; g++) begin : g_scale
    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        mult_r[g] <= (g < NUM_CH) ? RST_MULT_I16 : (g < 2 * NUM_CH) ? RST_MULT_I32 : RST_MULT_FLT;
        div_r[g]  <= RST_DIV;
      end else if (req_in.wr && wr_hit && wr_ent == 4'(g)) begin
        if (!wr_is_div) begin
          mult_r[g] <= req_in.wdata;
        end else if (req_in.wdata != 16'h0000) begin
          div_r[g] <= req_in.wdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register read decode and answer
  // ---------------------------------------------------------------------------
  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.valid = req_in.rd | req_in.wr;
    rsp_nxt.err   = 1'b1;
    // both strobes set counts as a write; anything not matched below is refused
    if (req_in.wr) begin
      // only scaling words take writes; data and overflow words are read-only
      rsp_nxt.err = !(wr_hit && (!wr_is_div || req_in.wdata != 16'h0000));
    end else if (req_in.rd) begin
      // scaling words read back as last written
      if (wr_hit) begin
        rsp_nxt.err   = 1'b0;
        rsp_nxt.rdata = wr_is_div ? div_r[wr_ent] : mult_r[wr_ent];
      end
      if (req_in.addr == ADDR_I16_OVF) begin
        rsp_nxt.err   = 1'b0;
        rsp_nxt.rdata = {11'h000, ovf16_r};
      end
      if (req_in.addr == ADDR_I32_OVF) begin
        rsp_nxt.err   = 1'b0;
        rsp_nxt.rdata = {11'h000, ovf32_r};
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (req_in.addr == ADDR_I16_CUR_A + 16'(c)) begin
          rsp_nxt.err   = 1'b0;
          rsp_nxt.rdata = res_r[c][15:0];
        end
        // 32-bit views: even offset high word, odd offset low word; no latch, so reads can tear
        if (req_in.addr[15:1] == 15'((ADDR_I32_CUR_A + 16'(2 * c)) >> 1)) begin
          rsp_nxt.err   = 1'b0;
          rsp_nxt.rdata = req_in.addr[0] ? res_r[NUM_CH + c][15:0] : res_r[NUM_CH + c][31:16];
        end
        if (req_in.addr[15:1] == 15'((ADDR_FLT_CUR_A + 16'(2 * c)) >> 1)) begin
          rsp_nxt.err   = 1'b0;
          rsp_nxt.rdata = req_in.addr[0] ? res_r[2 * NUM_CH + c][15:0] : res_r[2 * NUM_CH + c][31:16];
        end
      end
    end
  end

  // answer registered: it stands for exactly the cycle after the request edge
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // both outputs come straight from flops
  assign rsp_out        = rsp_r;
  assign sweep_done_out = sweep_done_r;

endmodule : scs_current_scaler

// File: scs_current_scaler_chk.sv
`timescale 1ns/10ps
module scs_current_scaler_chk (
  input wire logic               clk_sys_in,
  input wire logic               sys_rst_in,
  input wire logic               meas_valid_in,
  input wire scs_pkg::scs_meas_t meas_in,
  input wire scs_pkg::scs_req_t  req_in,
  input wire scs_pkg::scs_rsp_t  rsp_out,
  input wire logic               sweep_done_out
);
  import scs_pkg::*;
  // -------------------------------------------------------------
  // register port answers and sweep-end spacing
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // request edge, then the accepted or refused answer
  sequence s_req; req_in.rd || req_in.wr; endsequence
  sequence s_ok; rsp_out.valid && !rsp_out.err; endsequence
  sequence s_bad; rsp_out.valid && rsp_out.err; endsequence
  property p_answer; s_req |=> rsp_out.valid; endproperty
  property p_quiet; !(req_in.rd || req_in.wr) |=> !rsp_out.valid; endproperty
  property p_ro_write; req_in.wr && req_in.addr < ADDR_SCALE_BASE |=> s_bad; endproperty
  property p_mult_write; req_in.wr && req_in.addr == ADDR_SCALE_BASE |=> s_ok; endproperty
  property p_div_zero;
    req_in.wr && req_in.addr >= ADDR_SCALE_BASE && req_in.addr[0] && req_in.wdata == 16'h0000 |=> s_bad;
  endproperty
  property p_no_id;
    req_in.rd && !req_in.wr && req_in.addr == 16'h0000 |=> s_bad ##0 rsp_out.rdata == 16'h0000;
  endproperty
  property p_ovf16_top;
    req_in.rd && !req_in.wr && req_in.addr == ADDR_I16_OVF |=> s_ok ##0 rsp_out.rdata[15:5] == 11'h000;
  endproperty
  property p_ovf32_top;
    req_in.rd && !req_in.wr && req_in.addr == ADDR_I32_OVF |=> s_ok ##0 rsp_out.rdata[15:5] == 11'h000;
  endproperty
  // fifteen computations lie between two sweep ends, so pulses never bunch
  property p_sweep_gap; sweep_done_out |=> (!sweep_done_out) [*8]; endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  a_quiet: assert property (p_quiet) else $error("answer without request");
  a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");
  a_mult_write: assert property (p_mult_write) else $error("multiplier write refused");
  a_div_zero: assert property (p_div_zero) else $error("zero divider accepted");
  a_no_id: assert property (p_no_id) else $error("unmapped read accepted");
  a_ovf16_top: assert property (p_ovf16_top) else $error("unused flag bits set");
  a_ovf32_top: assert property (p_ovf32_top) else $error("unused flag bits set");
  a_sweep_gap: assert property (p_sweep_gap) else $error("sweep end too soon");
endmodule : scs_current_scaler_chk

// File: scs_current_scaler_test.sv
`timescale 1ns/10ps
module scs_current_scaler_test;
  import scs_pkg::*;
  logic        clk_sys_in    = 1'b0;
  logic        sys_rst_in    = 1'b1;
  logic        meas_valid_in = 1'b0;
  scs_meas_t   meas_in       = '0;
  scs_req_t    req_in;
  scs_rsp_t    rsp_out;
  logic        sweep_done_out;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [15:0] mu[3][5];
  logic [15:0] dv[3][5];
  int          n_mismatch = 0;
  int          cmp_count  = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  scs_current_scaler i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .meas_valid_in(meas_valid_in),
    .meas_in(meas_in), .req_in(req_in), .rsp_out(rsp_out), .sweep_done_out(sweep_done_out));
  scs_master_model i_master (.clk_sys_in(clk_sys_in), .req_out(req_in));

  // -------------------------------------------------------------
  // checking and verdict
  // -------------------------------------------------------------
  task check(input logic [16:0] seen, input logic [16:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, expd);
    end
  endtask : check

  task print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // oldest note against each answer; writes compare the refusal flag only
  always @(posedge clk_sys_in) begin
    if (rsp_out.valid === 1'b1) begin
      if (exp_q.size() == 0) check(17'h1FFFF, 17'h00000);
      else begin
        e = exp_q.pop_front();
        check({rsp_out.err, e[17] ? rsp_out.rdata : 16'h0000}, e[16:0]);
      end
    end
  end

  // -------------------------------------------------------------
  // reference arithmetic
  // -------------------------------------------------------------
  function automatic logic [31:0] to_flt(input logic [49:0] q);
    int p;
    logic [49:0] m;
    p = -1;
    for (int i = 0; i < 50; i++) if (q[i]) p = i;
    if (p < 0) return 32'h00000000;
    m = (p >= 23) ? q >> (p - 23) : q << (23 - p);
    return {1'b0, 8'(p) + FLT_EXP_OFFSET, m[22:0]};
  endfunction : to_flt

  // flag in bit 32; the product limit is checked before the divide, as the datapath must
  function automatic logic [32:0] calc(input int blk, input logic [33:0] x, input logic [15:0] m, input logic [15:0] d);
    logic [49:0] pr;
    logic [49:0] q;
    logic [31:0] lim;
    pr  = 50'(x) * 50'(m);
    q   = pr / 50'(d);
    lim = (blk == 0) ? SAT_I16 : SAT_I32;
    if (blk == 2) return {1'b0, to_flt(q)};
    if (pr > MAX_INTERMEDIATE || (q >> FRAC_W) > 50'(lim)) return {1'b1, lim};
    return {1'b0, 32'(q >> FRAC_W)};
  endfunction : calc

  // -------------------------------------------------------------
  // drivers
  // -------------------------------------------------------------
  task rd(input logic [15:0] a, input logic [15:0] d, input logic er);
    exp_q.push_back({1'b1, er, d});
    i_master.put(1'b1, 1'b0, a, 16'($urandom));
  endtask : rd

  task wr(input logic [15:0] a, input logic [15:0] d, input logic er);
    exp_q.push_back({1'b0, er, 16'h0000});
    i_master.put(1'b0, 1'b1, a, d);
  endtask : wr

  // released bus shows changing junk, never the last request
  task idle;
    i_master.put(1'b0, 1'b0, 16'($urandom), 16'($urandom));
  endtask : idle

  // new reading, then two sweep ends so every view holds it; reads follow at once to avoid tearing
  task sweep(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    logic [33:0] x[5];
    logic [32:0] r;
    logic [4:0]  ovf;
    logic [15:0] base;
    int n;
    @(posedge clk_sys_in);
    #1 meas_in = '{cur_a: a, cur_b: b, cur_c: c};
    meas_valid_in = 1'b1;
    @(posedge clk_sys_in);
    #1 meas_valid_in = 1'b0;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_sys_in);
        #1 n++;
      end while (sweep_done_out !== 1'b1 && n < 2000);
      if (n >= 2000) check(17'h1FFFF, 17'h00000);
    end
    x[0] = 34'(a);
    x[1] = 34'(b);
    x[2] = 34'(c);
    x[4] = x[0] + x[1] + x[2];
    x[3] = x[4] / 34'd3;
    for (int blk = 0; blk < 3; blk++) begin
      ovf  = 5'h00;
      base = (blk == 1) ? ADDR_I32_CUR_A : ADDR_FLT_CUR_A;
      for (int ch = 0; ch < 5; ch++) begin
        r = calc(blk, x[ch], mu[blk][ch], dv[blk][ch]);
        ovf[ch] = r[32];
        if (blk == 0) rd(16'(ADDR_I16_CUR_A + ch), r[15:0], 1'b0);
        else begin
          rd(16'(base + 2 * ch), r[31:16], 1'b0);
          rd(16'(base + 2 * ch + 1), r[15:0], 1'b0);
        end
      end
      if (blk == 0) rd(ADDR_I16_OVF, {11'h000, ovf}, 1'b0);
      if (blk == 1) rd(ADDR_I32_OVF, {11'h000, ovf}, 1'b0);
    end
    idle;
  endtask : sweep

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    void'($urandom(73822));
    for (int i = 0; i < 5; i++) begin
      mu[0][i] = RST_MULT_I16;
      mu[1][i] = RST_MULT_I32;
      mu[2][i] = RST_MULT_FLT;
      for (int j = 0; j < 3; j++) dv[j][i] = RST_DIV;
    end
    repeat (5) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    for (int blk = 0; blk < 3; blk++) begin
      rd(16'(ADDR_SCALE_BASE + blk * 16), mu[blk][0], 1'b0);
      rd(16'(ADDR_SCALE_BASE + blk * 16 + 9), dv[blk][4], 1'b0);
    end
    rd(16'h0000, 16'h0000, 1'b1);
    wr(ADDR_I16_CUR_A, 16'h1234, 1'b1);
    wr(ADDR_I16_OVF, 16'h001F, 1'b1);
    rd(ADDR_I16_OVF, 16'h0000, 1'b0);
    idle;
    // 2000 A on channel A clamps the 16-bit view
    sweep(32'h07D00000, $urandom_range(32'h00FFFFFF), $urandom_range(32'h00FFFFFF));
    // rescale: product limit on int32 total, scaled float A, zero divider refused
    wr(16'h0318, 16'hFFFF, 1'b0);
    mu[1][4] = 16'hFFFF;
    wr(16'h0319, 16'h0100, 1'b0);
    dv[1][4] = 16'h0100;
    wr(16'h0320, 16'h0003, 1'b0);
    mu[2][0] = 16'h0003;
    wr(16'h0321, 16'h0002, 1'b0);
    dv[2][0] = 16'h0002;
    wr(16'h0321, 16'h0000, 1'b1);
    rd(16'h0321, 16'h0002, 1'b0);
    idle;
    sweep(32'hF0000000 | 32'($urandom_range(32'h0FFFFFFF)), 32'hF0000000 | 32'($urandom_range(32'h0FFFFFFF)),
          32'hF0000000 | 32'($urandom_range(32'h0FFFFFFF)));
    // back in range, every flag must drop
    sweep($urandom_range(32'h003FFFFF), $urandom_range(32'h003FFFFF), $urandom_range(32'h003FFFFF));
    repeat (4) @(posedge clk_sys_in);
    if (exp_q.size() != 0) check(17'h1FFFF, 17'h00000);
    print_verdict;
  end

  // three sweeps of two passes each need about 5000 cycles
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
endmodule : scs_current_scaler_test

bind scs_current_scaler scs_current_scaler_chk i_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .meas_valid_in(meas_valid_in), .meas_in(meas_in), .req_in(req_in), .rsp_out(rsp_out),
  .sweep_done_out(sweep_done_out));

// File: scs_master_model.sv
`timescale 1ns/10ps
module scs_master_model (
  input  wire logic         clk_sys_in,
  output scs_pkg::scs_req_t req_out
);
  import scs_pkg::*;
  // one request per call, held over its sampling edge; the next call replaces it
  task automatic put(input logic rd, input logic wr, input logic [15:0] addr, input logic [15:0] wdata);
    @(posedge clk_sys_in);
    #1 req_out = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
  endtask : put
  initial req_out = '0;
endmodule : scs_master_model

// File: scs_pkg.sv
package scs_pkg;

  // ---------------------------------------------------------------------------
  // register map, word offsets on the register port
  // ---------------------------------------------------------------------------
  localparam logic [15:0] ADDR_I16_CUR_A   = 16'h0001;  // phase_one_current_16, channels follow
  localparam logic [15:0] ADDR_I16_OVF     = 16'h0006;  // overflow_flags_16
  localparam logic [15:0] ADDR_I32_CUR_A   = 16'h0102;  // high word, low word at +1
  localparam logic [15:0] ADDR_I32_OVF     = 16'h010C;
  localparam logic [15:0] ADDR_FLT_CUR_A   = 16'h0202;  // high word, low word at +1
  localparam logic [15:0] ADDR_SCALE_BASE  = 16'h0300;  // multiplier at +2*ch, divider at +2*ch+1
  localparam logic [15:0] ADDR_SCALE_STEP  = 16'h0010;  // spacing between scaling blocks

  // ---------------------------------------------------------------------------
  // sizes and field layout
  // ---------------------------------------------------------------------------
  localparam int          NUM_CH           = 5;         // A, B, C, average, total
  localparam int          NUM_BLK          = 3;         // int16, int32, float
  localparam int          PROD_W           = 50;        // 34-bit measurement times 16-bit multiplier
  localparam int          FRAC_W           = 16;        // measurement fraction bits (amperes, Q16.16)
  localparam logic [49:0] MAX_INTERMEDIATE = 50'h0FFFFFFFFFFFF;  // 48-bit internal limit
  localparam logic [31:0] SAT_I16          = 32'h0000FFFF;
  localparam logic [31:0] SAT_I32          = 32'hFFFFFFFF;
  localparam logic [7:0]  FLT_EXP_OFFSET   = 8'h6F;     // 127 bias minus 16 fraction bits
  localparam logic [5:0]  DIV_STEPS_LAST   = 6'h31;     // 50 quotient bits, counted down to zero

  // ---------------------------------------------------------------------------
  // reset values of the scaling registers
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_MULT_I16     = 16'h0064;  // 100
  localparam logic [15:0] RST_MULT_I32     = 16'h03E8;  // 1000
  localparam logic [15:0] RST_MULT_FLT     = 16'h0001;
  localparam logic [15:0] RST_DIV          = 16'h0001;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCS_MODE_I16 = 2'h0,
    SCS_MODE_I32 = 2'h1,
    SCS_MODE_FLT = 2'h2
  } scs_mode_t;

  typedef struct packed {
    logic [31:0] cur_a;  // amperes, unsigned Q16.16
    logic [31:0] cur_b;
    logic [31:0] cur_c;
  } scs_meas_t;

  typedef struct packed {
    logic        rd;     // single register read
    logic        wr;     // single register write
    logic [15:0] addr;
    logic [15:0] wdata;
  } scs_req_t;

  typedef struct packed {
    logic        valid;  // one-cycle answer
    logic        err;    // unmapped address, read-only target or zero divider
    logic [15:0] rdata;
  } scs_rsp_t;

endpackage : scs_pkg

// File: scs_scaler.sv
`timescale 1ns/10ps
module scs_scaler (
  input  wire logic            clk_sys_in,
  input  wire logic            sys_rst_in,
  input  wire logic            start_in,
  input  wire scs_pkg::scs_mode_t mode_in,
  input  wire logic [33:0]     meas_in,
  input  wire logic [15:0]     mult_in,
  input  wire logic [15:0]     div_in,
  output logic                 done_out,
  output logic [31:0]          result_out,
  output logic                 ovf_out
);
  import scs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DIV  = 3'b010,
    ST_PACK = 3'b100
  } scs_sc_state_t;

  scs_sc_state_t state_r;
  scs_mode_t     mode_r;
  logic [49:0]   num_r;
  logic [15:0]   rem_r;
  logic [15:0]   div_r;
  logic [5:0]    cnt_r;
  logic          big_r;
  logic [49:0]   prod;
  logic [16:0]   rem_sh;
  logic          fit;
  logic [33:0]   intg;
  logic [5:0]    msb;
  logic [49:0]   norm;
  logic [31:0]   flt;

  // ---------------------------------------------------------------------------
  // datapath helpers
  // ---------------------------------------------------------------------------
  assign prod   = 50'(meas_in) * 50'(mult_in);
  assign rem_sh = {rem_r, num_r[PROD_W-1]};
  assign fit    = $unsigned(rem_sh) >= {1'b0, div_r};
  assign intg   = num_r[PROD_W-1:FRAC_W];

  // leading one of the quotient sets the float exponent
  always_comb begin
    msb = 6'h00;
    for (int i = 0; i < PROD_W; i++) begin
      if (num_r[i]) begin
        msb = 6'(i);
      end
    end
    norm = num_r << (6'(PROD_W - 1) - msb);
    // truncation, not rounding: large values simply lose low bits
    flt  = (num_r == '0) ? 32'h00000000 :
           {1'b0, 8'(msb) + FLT_EXP_OFFSET, norm[48:26]};
  end

  // ---------------------------------------------------------------------------
  // multiply, then restoring divide one quotient bit per cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      mode_r  <= SCS_MODE_I16;
      num_r   <= '0;
      rem_r   <= 16'h0000;
      div_r   <= RST_DIV;
      cnt_r   <= 6'h00;
      big_r   <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_in) begin
            num_r   <= prod;
            rem_r   <= 16'h0000;
            div_r   <= div_in;
            mode_r  <= mode_in;
            cnt_r   <= DIV_STEPS_LAST;
            big_r   <= prod > MAX_INTERMEDIATE;
            state_r <= ST_DIV;
          end
        end
        ST_DIV: begin
          rem_r   <= fit ? 16'(rem_sh - {1'b0, div_r}) : rem_sh[15:0];
          num_r   <= {num_r[PROD_W-2:0], fit};
          cnt_r   <= cnt_r - 6'h01;
          if (cnt_r == 6'h00) begin
            state_r <= ST_PACK;
          end
        end
        ST_PACK: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // saturate integer views, float view passes unclamped
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      done_out   <= 1'b0;
      result_out <= 32'h00000000;
      ovf_out    <= 1'b0;
    end else begin
      done_out <= state_r == ST_PACK;
      if (state_r == ST_PACK) begin
        case (mode_r)
          SCS_MODE_I16: begin
            ovf_out    <= big_r | (|intg[33:16]);
            result_out <= (big_r | (|intg[33:16])) ? SAT_I16 : {16'h0000, intg[15:0]};
          end
          SCS_MODE_I32: begin
            ovf_out    <= big_r | (|intg[33:32]);
            result_out <= (big_r | (|intg[33:32])) ? SAT_I32 : intg[31:0];
          end
          default: begin
            ovf_out    <= 1'b0;
            result_out <= flt;
          end
        endcase
      end
    end
  end

endmodule : scs_scaler
